// ### logic/lspm_framer.sv
`timescale 1ns/1ps

module lspm_fifo #(
  parameter int W = 36,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  wire logic push = in_valid_i && in_ready_o;
  wire logic pop = out_valid_o && out_ready_i;

  assign in_ready_o = cnt_reg != (AW+1)'(DEPTH);
  assign out_valid_o = cnt_reg != '0;
  assign out_data_o = mem[rd_reg];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module lspm_framer #(
  parameter int NUM_CH = 4,
  parameter int FIFO_DEPTH = lspm_pkg::FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [4:0] lane_format_select_i,
  input wire lspm_pkg::lspm_set_s smp_i,
  input wire logic smp_valid_i,
  output logic smp_ready_o,
  output lspm_pkg::lspm_lanes_t lane_data_o,
  output logic frame_valid_o,
  output logic frame_eleven_o,
  input wire logic frame_ready_i,
  output logic format_err_o
);
  localparam int SW = lspm_pkg::SAMPLE_W;
  lspm_pkg::lspm_set_s set_w;
  logic set_valid;
  logic take;
  lspm_pkg::lspm_state_e state_reg;
  lspm_pkg::lspm_state_e state_next;
  logic [4:0] idx_reg;
  logic m11_reg;
  logic [SW-1:0] last_a_reg;
  lspm_pkg::lspm_lanes_t lane_reg;
  lspm_pkg::lspm_lanes_t out_reg;
  logic err_reg;

  lspm_fifo #(
    .W($bits(lspm_pkg::lspm_set_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .in_data_i(smp_i),
    .in_valid_i(smp_valid_i),
    .in_ready_o(smp_ready_o),
    .out_data_o(set_w),
    .out_valid_o(set_valid),
    .out_ready_i(state_reg == lspm_pkg::LSPM_FILL)
  );

  // Format eleven is refused on the quad variant and falls back to ten.
  wire logic sel_eleven = lane_format_select_i == lspm_pkg::FMT_ELEVEN;
  wire logic cur_m11 = sel_eleven && (NUM_CH <= 2);
  wire logic cur_err = (sel_eleven && !cur_m11) ||
    (!sel_eleven && lane_format_select_i != lspm_pkg::FMT_TEN);
  // The format is frozen for a whole frame at its first sample.
  wire logic m11 = (idx_reg == '0) ? cur_m11 : m11_reg;
  wire logic [4:0] last_idx = m11 ? lspm_pkg::LAST_ELEVEN
                                  : lspm_pkg::LAST_TEN;
  wire logic frame_end = take && idx_reg == last_idx;
  wire logic clear = state_reg == lspm_pkg::LSPM_SEND && frame_ready_i;

  assign take = state_reg == lspm_pkg::LSPM_FILL && set_valid;
  assign frame_valid_o = state_reg == lspm_pkg::LSPM_SEND;
  assign frame_eleven_o = m11_reg;
  assign lane_data_o = out_reg;
  assign format_err_o = err_reg;

  always_comb begin
    case (state_reg)
      lspm_pkg::LSPM_FILL: begin
        state_next = frame_end ? lspm_pkg::LSPM_PACK : lspm_pkg::LSPM_FILL;
      end
      lspm_pkg::LSPM_PACK: begin
        state_next = lspm_pkg::LSPM_SEND;
      end
      lspm_pkg::LSPM_SEND: begin
        state_next = frame_ready_i ? lspm_pkg::LSPM_FILL : lspm_pkg::LSPM_SEND;
      end
      default: begin
        state_next = lspm_pkg::LSPM_FILL;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= lspm_pkg::LSPM_FILL;
      idx_reg <= '0;
      m11_reg <= 1'b0;
      err_reg <= 1'b0;
      last_a_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (take) begin
        idx_reg <= frame_end ? '0 : idx_reg + 5'h01;
        m11_reg <= m11;
        last_a_reg <= set_w.ch[0];
      end
      if (take && idx_reg == '0) begin
        err_reg <= cur_err;
      end
    end
  end

  for (genvar l = 0; l < lspm_pkg::LANES; l++) begin : g_lane
    localparam int C10 = l / 2;
    localparam int C11 = l / 4;
    localparam logic P10 = 1'(l % 2);
    localparam logic [1:0] P11 = 2'(l % 4);
    // Even samples on the even lane of a pair, odd on the odd lane.
    wire logic sh10 = take && !m11 && idx_reg[0] == P10 &&
      (C10 < NUM_CH);
    // Sample k of a channel goes to that channel's lane k mod 4.
    wire logic sh11 = take && m11 && idx_reg[1:0] == P11 &&
      (C11 < NUM_CH);

    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        lane_reg[l] <= '0;
        out_reg[l] <= '0;
      end else begin
        if (clear) begin
          lane_reg[l] <= '0;
        end else if (sh10) begin
          lane_reg[l] <= {lane_reg[l][53:0], set_w.ch[C10],
            lspm_pkg::PAD_TEN};
        end else if (sh11) begin
          lane_reg[l] <= {lane_reg[l][51:0], set_w.ch[C11],
            lspm_pkg::PAD_ELEVEN};
        end
        if (state_reg == lspm_pkg::LSPM_PACK) begin
          out_reg[l] <= m11_reg ?
            {lane_reg[l][59:0], lspm_pkg::TAIL_NIBBLE} :
            {lane_reg[l][39:0], lspm_pkg::FILL_TEN};
        end
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_held;
    frame_valid_o && !frame_ready_i;
  endsequence

  sequence s_still;
    frame_valid_o && $stable(lane_data_o);
  endsequence

  a_frame_held_stable: assert property (s_held |=> s_still)
    else $error("frame changed while held");

  a_ten_unused_lanes: assert property (frame_valid_o && !frame_eleven_o
    |-> (NUM_CH == 4 || lane_data_o[7] == '0))
    else $error("unused lane carries data in format ten");

  a_ten_pad_bits: assert property (frame_valid_o && !frame_eleven_o |->
    !lane_data_o[2][54] && !lane_data_o[2][44] && !lane_data_o[2][34] &&
    !lane_data_o[2][24] && lane_data_o[2][23:0] == '0)
    else $error("format ten pad bits not zero");

  a_ten_odd_last: assert property ($rose(frame_valid_o) && !frame_eleven_o
    |-> lane_data_o[1][33:25] == last_a_reg)
    else $error("last odd sample not on odd lane");

  a_eleven_variant: assert property (frame_valid_o && frame_eleven_o
    |-> NUM_CH <= 2 && (NUM_CH == 2 || lane_data_o[4] == '0))
    else $error("format eleven on wrong variant or lane");

  a_eleven_tail_last: assert property ($rose(frame_valid_o) &&
    frame_eleven_o |-> lane_data_o[3][3:0] == lspm_pkg::TAIL_NIBBLE &&
    lane_data_o[3][6:4] == '0 &&
    lane_data_o[3][15:7] == last_a_reg)
    else $error("format eleven tail or last slot wrong");

  a_pack_then_send: assert property (frame_end |=> ##1 frame_valid_o)
    else $error("frame not presented two cycles after last sample");
endmodule

// ### logic/lspm_pkg.sv
package lspm_pkg;
  localparam int SAMPLE_W = 9;
  localparam int LANES = 8;
  localparam int LANE_W = 64;
  localparam int CHANNELS = 4;
  localparam int FIFO_DEPTH = 8;
  localparam logic [4:0] FMT_TEN = 5'h0A;
  localparam logic [4:0] FMT_ELEVEN = 5'h0B;
  localparam logic [4:0] LAST_TEN = 5'h07;
  localparam logic [4:0] LAST_ELEVEN = 5'h13;
  localparam logic [3:0] TAIL_NIBBLE = 4'h0;
  localparam logic [2:0] PAD_ELEVEN = 3'h0;
  localparam logic PAD_TEN = 1'b0;
  localparam logic [23:0] FILL_TEN = 24'h000000;

  typedef struct packed {
    logic [CHANNELS-1:0][SAMPLE_W-1:0] ch;
  } lspm_set_s;

  typedef logic [LANES-1:0][LANE_W-1:0] lspm_lanes_t;

  typedef enum logic [1:0] {
    LSPM_FILL = 2'b00,
    LSPM_PACK = 2'b01,
    LSPM_SEND = 2'b10
  } lspm_state_e;
endpackage

// ### dv/lspm_rx_model.sv
`timescale 1ns/1ps

module lspm_rx_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic slow_i,
  output logic frame_ready_o
);
  // A slow receiver takes a frame on about one edge in four.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frame_ready_o <= 1'b0;
    end else begin
      frame_ready_o <= !slow_i || ($urandom % 4 == 0);
    end
  end
endmodule

// ### dv/tb.sv
`timescale 1ns/1ps

module tb;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic smp_valid_i = 1'b0;
  logic slow = 1'b0;
  logic [4:0] sel = 5'h0A;
  lspm_pkg::lspm_set_s smp_i = '0;
  lspm_pkg::lspm_lanes_t lane_data_o;
  logic smp_ready_o, frame_valid_o, frame_eleven_o, frame_ready_i;
  logic format_err_o;
  lspm_pkg::lspm_lanes_t exp_q[$];
  logic [1:0] flg_q[$];
  logic [4:0] fmts [5] = '{5'h0A, 5'h0B, 5'h03, 5'h0B, 5'h0A};
  int fails = 0;
  int num_checks = 0;

  lspm_framer #(.NUM_CH(2), .FIFO_DEPTH(8)) dut_u (.clk_i(clk_i),
    .rstn_i(rstn_i), .lane_format_select_i(sel), .smp_i(smp_i),
    .smp_valid_i(smp_valid_i), .smp_ready_o(smp_ready_o),
    .lane_data_o(lane_data_o), .frame_valid_o(frame_valid_o),
    .frame_eleven_o(frame_eleven_o), .frame_ready_i(frame_ready_i),
    .format_err_o(format_err_o));

  lspm_rx_model rx_u (.clk_i(clk_i), .rstn_i(rstn_i), .slow_i(slow),
    .frame_ready_o(frame_ready_i));

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  task automatic final_report();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Every output must sit at its idle value right after a reset release.
  task automatic check_idle();
    num_checks++;
    if (smp_ready_o !== 1'b1 || frame_valid_o !== 1'b0 ||
        lane_data_o !== '0 || frame_eleven_o !== 1'b0 ||
        format_err_o !== 1'b0) begin
      fails++;
      $display("ERROR %0t wrong state after reset", $time);
    end
  endtask

  // Leaves a frame three sets in, then resets in mid-run.
  task automatic mid_reset();
    smp_i.ch[0] = 9'($urandom);
    smp_valid_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    smp_valid_i = 1'b0;
    rstn_i = 1'b0;
    @(posedge clk_i);
    #1;
    rstn_i = 1'b1;
    check_idle();
  endtask

  // Sends one whole frame of sets and notes the lanes it must produce.
  task automatic frame(input logic [4:0] f);
    int n, c, s, k;
    logic el, r;
    lspm_pkg::lspm_lanes_t e;
    el = (f == lspm_pkg::FMT_ELEVEN);
    e = '0;
    sel = f;
    for (n = 0; n < (el ? 20 : 8); n++) begin
      for (c = 0; c < 4; c++) begin
        smp_i.ch[c] = 9'($urandom);
        s = el ? n / 4 : n / 2;
        if (c < 2 && el) e[4*c+n%4][63-12*s -: 12] = {smp_i.ch[c], 3'h0};
        if (c < 2 && !el) e[2*c+n%2][63-10*s -: 10] = {smp_i.ch[c], 1'b0};
      end
      smp_valid_i = 1'b1;
      k = 0;
      do begin
        @(negedge clk_i);
        r = smp_ready_o;
        @(posedge clk_i);
        k++;
      end while (!r && k < 300);
      if (!r) begin
        fails++;
        $display("ERROR %0t sample input never ready", $time);
        final_report();
      end
      #1;
    end
    smp_valid_i = 1'b0;
    exp_q.push_back(e);
    flg_q.push_back({el, f != lspm_pkg::FMT_TEN && !el});
    @(posedge clk_i);
    #1;
  endtask

  always @(negedge clk_i) begin
    if (rstn_i && frame_valid_o && frame_ready_i) begin
      num_checks++;
      if (exp_q.size() == 0 || lane_data_o !== exp_q[0] ||
          {frame_eleven_o, format_err_o} !== flg_q[0]) begin
        fails++;
        $display("ERROR %0t frame content mismatch", $time);
      end
      if (exp_q.size() != 0) begin
        void'(exp_q.pop_front());
        void'(flg_q.pop_front());
      end
    end
  end

  initial begin
    int i, k;
    void'($urandom(87));
    repeat (5) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    check_idle();
    for (i = 0; i < 5; i++) begin
      slow = i[0];
      if (i == 4) begin
        mid_reset();
      end
      frame(fmts[i]);
      frame(fmts[i]);
      k = 0;
      while (exp_q.size() != 0 && k < 600) begin
        @(posedge clk_i);
        k++;
      end
      #1;
      if (exp_q.size() != 0) begin
        fails++;
        $display("ERROR %0t frames not accepted in time", $time);
        final_report();
      end
      $display("test %0d done, format %0h", i, fmts[i]);
    end
    final_report();
  end
endmodule
